// ===== pkg/crs_cfg.svh
`ifndef CRS_CFG_SVH
`define CRS_CFG_SVH
// register byte offsets on the slave bus
`define CRS_OFS_FLAGS 6'h00
`define CRS_OFS_ACC 6'h04
`define CRS_OFS_BC 6'h08
`define CRS_OFS_DE 6'h0c
`define CRS_OFS_HL 6'h10
`define CRS_OFS_IDXA 6'h14
`define CRS_OFS_IDXB 6'h18
`define CRS_OFS_SP 6'h1c
`define CRS_OFS_PC 6'h20
`define CRS_OFS_VBASE 6'h24
`define CRS_OFS_REFRESH 6'h28
// condition flag bit positions
`define CRS_FLG_SIGN 7
`define CRS_FLG_ZERO 6
`define CRS_FLG_HALF 4
`define CRS_FLG_PV 2
`define CRS_FLG_SUB 1
`define CRS_FLG_CARRY 0
// defined flag bits; bits 5 and 3 read as zero
`define CRS_FLG_MASK 8'hd7
// reset values
`define CRS_RST_FLAGS 8'h00
`define CRS_RST_VBASE 8'h00
`define CRS_RST_REFRESH 8'h00
`define CRS_RST_SP 16'h0000
`define CRS_RST_PC 16'h0000
`define CRS_RST_GEN 16'h0000
// 8-bit register select codes
`define CRS_R8_B 3'h0
`define CRS_R8_C 3'h1
`define CRS_R8_D 3'h2
`define CRS_R8_E 3'h3
`define CRS_R8_H 3'h4
`define CRS_R8_L 3'h5
`define CRS_R8_NONE 3'h6
`define CRS_R8_A 3'h7
// pair select codes
`define CRS_PR_BC 2'h0
`define CRS_PR_DE 2'h1
`define CRS_PR_MID 2'h2
`define CRS_PR_TOP 2'h3
`endif

// ===== pkg/crs_pkg.sv
package crs_pkg;
   // operation class that drives the flag update
   typedef enum logic [2:0] {
      CRS_ALU_LOGIC = 3'h0,
      CRS_ALU_ADD8 = 3'h1,
      CRS_ALU_SUB8 = 3'h2,
      CRS_ALU_ADD16 = 3'h3,
      CRS_ALU_SUB16 = 3'h4,
      CRS_ALU_SHIFT = 3'h5
   } crs_alu_t;
   // which field variant the pair select belongs to
   typedef enum logic [1:0] {
      CRS_VAR_HL = 2'h0,
      CRS_VAR_IDXA = 2'h1,
      CRS_VAR_IDXB = 2'h2,
      CRS_VAR_AF = 2'h3
   } crs_var_t;
   // slave handshake state
   typedef enum logic [1:0] {
      CRS_BUS_IDLE = 2'b01,
      CRS_BUS_DONE = 2'b10
   } crs_bus_t;
endpackage : crs_pkg

// ===== logic/crs_register_set.sv
`include "crs_cfg.svh"

// Behaviour
// - vectored interrupts take vector table upper byte from vector base.
// - vector base register clears to zero on reset.
// - refresh counter low seven bits count each opcode fetch cycle.
// - refresh counter clears to zero on reset.
// - sixteen-bit stack pointer clears to zero on reset.
// - program counter clears to zero on reset; execution starts at zero.
// - program counter points at next instruction, advancing after each fetch.
// - sign flag bit 7 takes result most significant bit.
// - zero flag bit 6 set on zero result, cleared otherwise.
// - half-carry bit 4 holds carry or borrow out of bit 3 for 8-bit ops, out of bit 11 for 16-bit ops.
// - logical ops set parity bit 2 on even count of ones.
// - arithmetic sets overflow bit 2 when signed result leaves range.
// - subtract flag bit 1 set by subtracting ops, cleared by adding.
// - carry bit 0 from result msb carry; also set by shifts.
// - 3-bit select maps B,C,D,E,H,L,none,accumulator.
// - pair select maps BC, DE, HL/index, stack pointer or accum/flags.
// - high suffix picks upper byte of pair, low suffix lower byte.
// - register indirect address comes straight from BC, DE or HL.
// - indexed address is index register plus or minus displacement.
// - indexed displacement is signed 8-bit, with either index register.
module crs_register_set (
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic opcode_fetch_cycle,
   input wire logic pc_load,
   input wire logic [15:0] pc_load_value,
   input wire logic [7:0] vec_low,
   output logic [15:0] vector_addr,
   input wire logic alu_valid,
   input wire crs_pkg::crs_alu_t alu_kind,
   input wire logic [15:0] alu_a,
   input wire logic [15:0] alu_b,
   input wire logic alu_cin,
   input wire logic shift_cout,
   input wire logic wb_valid,
   input wire logic [2:0] wb_sel,
   input wire logic [7:0] wb_data,
   input wire logic [2:0] reg8_field,
   output logic [7:0] reg8_data,
   output logic reg8_valid,
   input wire logic [1:0] pair_field,
   input wire crs_pkg::crs_var_t pair_var,
   input wire logic half_high,
   output logic [15:0] pair_data,
   output logic [7:0] pair_half,
   input wire logic [1:0] ind_pair,
   input wire logic idx_mode,
   input wire logic idx_sel_b,
   input wire logic [7:0] idx_disp,
   input wire logic idx_sub,
   output logic [15:0] mem_addr,
   output logic [15:0] stack_pointer,
   output logic [15:0] program_counter,
   output logic [7:0] condition_flags
);

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [7:0] acc;
   logic [15:0] pair_bc;
   logic [15:0] pair_de;
   logic [15:0] pair_hl;
   logic [15:0] index_reg_a;
   logic [15:0] index_reg_b;
   logic [7:0] vbase;
   logic [7:0] refresh;
   crs_pkg::crs_bus_t bus_state;
   logic bus_req;
   logic bus_wr;
   logic [5:0] wr_ofs;

   ////////////////////////////////////////////////////////////////////////
   // functions

   // flag update from an operation class and its operands
   function automatic logic [7:0] calc_flags(
      input crs_pkg::crs_alu_t kind,
      input logic [15:0] a,
      input logic [15:0] b,
      input logic cin,
      input logic cout_sh,
      input logic [7:0] old
   );
      logic [16:0] r;
      logic [15:0] x;
      logic [15:0] a_e;
      logic [15:0] b_e;
      logic w16;
      logic sub;
      logic res_s;
      logic am;
      logic bm;
      logic [7:0] f;
      w16 = (kind == crs_pkg::CRS_ALU_ADD16) ||
            (kind == crs_pkg::CRS_ALU_SUB16);
      sub = (kind == crs_pkg::CRS_ALU_SUB8) ||
            (kind == crs_pkg::CRS_ALU_SUB16);
      a_e = w16 ? a : {8'h00, a[7:0]};
      b_e = w16 ? b : {8'h00, b[7:0]};
      if (sub) begin
         r = {1'b0, a_e} - {1'b0, b_e} - {16'h0000, cin};
      end else begin
         r = {1'b0, a_e} + {1'b0, b_e} + {16'h0000, cin};
      end
      x = a_e ^ b_e ^ r[15:0];
      res_s = w16 ? r[15] : r[7];
      am = w16 ? a[15] : a[7];
      bm = w16 ? b[15] : b[7];
      f = old & `CRS_FLG_MASK;
      unique case (kind)
         crs_pkg::CRS_ALU_LOGIC: begin
            f[`CRS_FLG_SIGN] = a[7];
            f[`CRS_FLG_ZERO] = (a[7:0] == 8'h00);
            f[`CRS_FLG_HALF] = 1'b0;
            f[`CRS_FLG_PV] = ~^a[7:0];
            f[`CRS_FLG_SUB] = 1'b0;
            f[`CRS_FLG_CARRY] = 1'b0;
         end
         crs_pkg::CRS_ALU_SHIFT: begin
            f[`CRS_FLG_HALF] = 1'b0;
            f[`CRS_FLG_SUB] = 1'b0;
            f[`CRS_FLG_CARRY] = cout_sh;
         end
         default: begin
            f[`CRS_FLG_SIGN] = res_s;
            f[`CRS_FLG_ZERO] = w16 ? (r[15:0] == 16'h0000)
                                   : (r[7:0] == 8'h00);
            f[`CRS_FLG_HALF] = w16 ? x[12] : x[4];
            f[`CRS_FLG_PV] = sub ? ((am != bm) && (res_s != am))
                                 : ((am == bm) && (res_s != am));
            f[`CRS_FLG_SUB] = sub;
            f[`CRS_FLG_CARRY] = w16 ? r[16] : r[8];
         end
      endcase
      return f;
   endfunction : calc_flags

   // 8-bit register select; bit 8 marks a real register
   function automatic logic [8:0] pick8(input logic [2:0] code);
      logic [8:0] v;
      v = 9'h000;
      unique case (code)
         `CRS_R8_B: v = {1'b1, pair_bc[15:8]};
         `CRS_R8_C: v = {1'b1, pair_bc[7:0]};
         `CRS_R8_D: v = {1'b1, pair_de[15:8]};
         `CRS_R8_E: v = {1'b1, pair_de[7:0]};
         `CRS_R8_H: v = {1'b1, pair_hl[15:8]};
         `CRS_R8_L: v = {1'b1, pair_hl[7:0]};
         `CRS_R8_NONE: v = 9'h000;
         `CRS_R8_A: v = {1'b1, acc};
      endcase
      return v;
   endfunction : pick8

   // pair select in one of the four field variants
   function automatic logic [15:0] pick16(
      input logic [1:0] code,
      input crs_pkg::crs_var_t var_sel
   );
      logic [15:0] v;
      v = pair_bc;
      unique case (code)
         `CRS_PR_BC: v = pair_bc;
         `CRS_PR_DE: v = pair_de;
         `CRS_PR_MID: begin
            unique case (var_sel)
               crs_pkg::CRS_VAR_IDXA: v = index_reg_a;
               crs_pkg::CRS_VAR_IDXB: v = index_reg_b;
               default: v = pair_hl;
            endcase
         end
         `CRS_PR_TOP: begin
            v = (var_sel == crs_pkg::CRS_VAR_AF)
                ? {acc, condition_flags} : stack_pointer;
         end
      endcase
      return v;
   endfunction : pick16

   ////////////////////////////////////////////////////////////////////////
   // avalon slave: waitrequest drops one cycle after a request
   logic sw_wr;
   assign sw_wr = bus_req && bus_wr;

   // handshake state
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         bus_state <= crs_pkg::CRS_BUS_IDLE;
         avs_waitrequest <= 1'b1;
      end else begin
         unique case (bus_state)
            crs_pkg::CRS_BUS_IDLE: begin
               if (avs_read || avs_write) begin
                  bus_state <= crs_pkg::CRS_BUS_DONE;
                  avs_waitrequest <= 1'b0;
               end
            end
            crs_pkg::CRS_BUS_DONE: begin
               bus_state <= crs_pkg::CRS_BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               bus_state <= crs_pkg::CRS_BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // write commits at the edge where waitrequest is low
   assign bus_req = (bus_state == crs_pkg::CRS_BUS_DONE);
   assign bus_wr = avs_write;
   assign wr_ofs = {avs_address[5:2], 2'b00};

   // read data, presented with waitrequest low
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (bus_state == crs_pkg::CRS_BUS_IDLE && avs_read) begin
         unique case (wr_ofs)
            `CRS_OFS_FLAGS:
               avs_readdata <= {24'h0, condition_flags};
            `CRS_OFS_ACC: avs_readdata <= {24'h0, acc};
            `CRS_OFS_BC: avs_readdata <= {16'h0, pair_bc};
            `CRS_OFS_DE: avs_readdata <= {16'h0, pair_de};
            `CRS_OFS_HL: avs_readdata <= {16'h0, pair_hl};
            `CRS_OFS_IDXA: avs_readdata <= {16'h0, index_reg_a};
            `CRS_OFS_IDXB: avs_readdata <= {16'h0, index_reg_b};
            `CRS_OFS_SP: avs_readdata <= {16'h0, stack_pointer};
            `CRS_OFS_PC: avs_readdata <= {16'h0, program_counter};
            `CRS_OFS_VBASE: avs_readdata <= {24'h0, vbase};
            `CRS_OFS_REFRESH: avs_readdata <= {24'h0, refresh};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // special registers

   // vector base
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         vbase <= `CRS_RST_VBASE;
      end else if (sw_wr && wr_ofs == `CRS_OFS_VBASE) begin
         vbase <= avs_writedata[7:0];
      end
   end

   // refresh counter: low seven bits wrap, msb kept
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         refresh <= `CRS_RST_REFRESH;
      end else if (sw_wr && wr_ofs == `CRS_OFS_REFRESH) begin
         refresh <= avs_writedata[7:0];
      end else if (opcode_fetch_cycle) begin
         refresh <= {refresh[7], refresh[6:0] + 7'h01};
      end
   end

   // stack pointer
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         stack_pointer <= `CRS_RST_SP;
      end else if (sw_wr && wr_ofs == `CRS_OFS_SP) begin
         stack_pointer <= avs_writedata[15:0];
      end
   end

   // program counter: load, else step after each fetch
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         program_counter <= `CRS_RST_PC;
      end else if (sw_wr && wr_ofs == `CRS_OFS_PC) begin
         program_counter <= avs_writedata[15:0];
      end else if (pc_load) begin
         program_counter <= pc_load_value;
      end else if (opcode_fetch_cycle) begin
         program_counter <= program_counter + 16'h0001;
      end
   end

   // vector table address for vectored interrupts
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         vector_addr <= 16'h0000;
      end else begin
         vector_addr <= {vbase, vec_low};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // condition flags
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         condition_flags <= `CRS_RST_FLAGS;
      end else if (sw_wr && wr_ofs == `CRS_OFS_FLAGS) begin
         condition_flags <= avs_writedata[7:0] & `CRS_FLG_MASK;
      end else if (alu_valid) begin
         condition_flags <= calc_flags(alu_kind, alu_a, alu_b, alu_cin,
                                       shift_cout, condition_flags);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // general registers, written by software or core writeback
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         acc <= 8'h00;
         pair_bc <= `CRS_RST_GEN;
         pair_de <= `CRS_RST_GEN;
         pair_hl <= `CRS_RST_GEN;
      end else if (sw_wr) begin
         if (wr_ofs == `CRS_OFS_ACC) acc <= avs_writedata[7:0];
         if (wr_ofs == `CRS_OFS_BC) pair_bc <= avs_writedata[15:0];
         if (wr_ofs == `CRS_OFS_DE) pair_de <= avs_writedata[15:0];
         if (wr_ofs == `CRS_OFS_HL) pair_hl <= avs_writedata[15:0];
      end else if (wb_valid) begin
         unique case (wb_sel)
            `CRS_R8_B: pair_bc[15:8] <= wb_data;
            `CRS_R8_C: pair_bc[7:0] <= wb_data;
            `CRS_R8_D: pair_de[15:8] <= wb_data;
            `CRS_R8_E: pair_de[7:0] <= wb_data;
            `CRS_R8_H: pair_hl[15:8] <= wb_data;
            `CRS_R8_L: pair_hl[7:0] <= wb_data;
            `CRS_R8_NONE: acc <= acc;
            `CRS_R8_A: acc <= wb_data;
         endcase
      end
   end

   // index registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         index_reg_a <= `CRS_RST_GEN;
         index_reg_b <= `CRS_RST_GEN;
      end else if (sw_wr) begin
         if (wr_ofs == `CRS_OFS_IDXA) index_reg_a <= avs_writedata[15:0];
         if (wr_ofs == `CRS_OFS_IDXB) index_reg_b <= avs_writedata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // decoded operands and operand address, one cycle after the fields
   logic [15:0] next_pair;
   logic [15:0] next_disp;
   logic [15:0] next_index;
   // always_comb so that a register change also reaches the pair mux
   always_comb begin
      next_pair = pick16(pair_field, pair_var);
   end
   assign next_disp = {{8{idx_disp[7]}}, idx_disp};
   assign next_index = idx_sel_b ? index_reg_b : index_reg_a;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         reg8_data <= 8'h00;
         reg8_valid <= 1'b0;
         pair_data <= 16'h0000;
         pair_half <= 8'h00;
         mem_addr <= 16'h0000;
      end else begin
         {reg8_valid, reg8_data} <= pick8(reg8_field);
         pair_data <= next_pair;
         pair_half <= half_high ? next_pair[15:8]
                                : next_pair[7:0];
         if (idx_mode) begin
            mem_addr <= idx_sub ? next_index - next_disp
                                : next_index + next_disp;
         end else begin
            unique case (ind_pair)
               `CRS_PR_DE: mem_addr <= pair_de;
               `CRS_PR_MID: mem_addr <= pair_hl;
               default: mem_addr <= pair_bc;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   logic no_flag_wr;
   assign no_flag_wr = !(sw_wr && wr_ofs == `CRS_OFS_FLAGS);

   vbase_reset_a: assert property (disable iff (1'b0)
      srst |=> ##1 vector_addr[15:8] == 8'h00)
      else $error("vector base not zero after reset");
   vector_byte_a: assert property (
      ##1 vector_addr == {$past(vbase), $past(vec_low)})
      else $error("vector address not from base");
   regs_reset_a: assert property (disable iff (1'b0)
      srst |=> stack_pointer == 16'h0000 && program_counter == 16'h0000
               && refresh == 8'h00)
      else $error("sp, pc or refresh not zero after reset");
   refresh_step_a: assert property (
      opcode_fetch_cycle && !sw_wr |=> refresh[6:0] ==
      $past(refresh[6:0]) + 7'h01 && refresh[7] == $past(refresh[7]))
      else $error("refresh did not step");
   pc_step_a: assert property (
      opcode_fetch_cycle && !sw_wr && !pc_load |=>
      program_counter == $past(program_counter) + 16'h0001)
      else $error("pc did not advance");
   parity_flag_a: assert property (
      alu_valid && alu_kind == crs_pkg::CRS_ALU_LOGIC && no_flag_wr |=>
      condition_flags[`CRS_FLG_PV] == ~^$past(alu_a[7:0]) &&
      condition_flags[`CRS_FLG_ZERO] == ($past(alu_a[7:0]) == 8'h00))
      else $error("parity or zero flag wrong");
   sub_flag_a: assert property (
      alu_valid && no_flag_wr && (alu_kind == crs_pkg::CRS_ALU_SUB8 ||
      alu_kind == crs_pkg::CRS_ALU_SUB16) |=> condition_flags[1])
      else $error("subtract flag not set");
   carry8_a: assert property (
      alu_valid && no_flag_wr && alu_kind == crs_pkg::CRS_ALU_ADD8 |=>
      condition_flags[0] == ({1'b0, $past(alu_a[7:0])} +
      {1'b0, $past(alu_b[7:0])} + {8'h00, $past(alu_cin)} > 9'h0ff))
      else $error("carry flag wrong");
   sel_none_a: assert property (
      reg8_field == `CRS_R8_NONE |=> !reg8_valid)
      else $error("code 110 selected a register");
   bus_answer_a: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest
      ##1 avs_waitrequest)
      else $error("slave answer not in one cycle");

   fetch_c: cover property (opcode_fetch_cycle ##1 opcode_fetch_cycle);
   wrap_c: cover property (opcode_fetch_cycle && refresh[6:0] == 7'h7f);
   sub_c: cover property (alu_valid && alu_kind == crs_pkg::CRS_ALU_SUB8);
   bus_wr_c: cover property (sw_wr);

endmodule : crs_register_set

// ===== bench/crs_testbench.sv
`include "crs_cfg.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////
   // flag update cases: kind, a, b, shift carry, flags
   typedef struct packed {
      logic [2:0] k;
      logic [15:0] a;
      logic [15:0] b;
      logic sc;
      logic [7:0] f;
   } crs_alu_case_t;
   // operand address cases
   typedef struct packed {
      logic md;
      logic sb;
      logic sub;
      logic [1:0] ip;
      logic [7:0] d;
      logic [15:0] e;
   } crs_addr_case_t;
   logic clk_sys, srst, avs_read, avs_write, avs_waitrequest;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic opcode_fetch_cycle, pc_load, alu_valid, alu_cin, shift_cout;
   logic wb_valid, reg8_valid, half_high, idx_mode, idx_sel_b, idx_sub;
   logic [15:0] pc_load_value, vector_addr, alu_a, alu_b, pair_data;
   logic [15:0] mem_addr, stack_pointer, program_counter;
   logic [7:0] vec_low, wb_data, reg8_data, pair_half, idx_disp;
   logic [7:0] condition_flags;
   logic [2:0] wb_sel, reg8_field;
   logic [1:0] pair_field, ind_pair;
   crs_pkg::crs_alu_t alu_kind;
   crs_pkg::crs_var_t pair_var;
   int mismatches, checks_done;
   crs_alu_case_t alu_tab [10] = '{
      '{3'h1, 16'h007f, 16'h0001, 1'b0, 8'h94},
      '{3'h2, 16'h0000, 16'h0001, 1'b0, 8'h93},
      '{3'h1, 16'h00ff, 16'h0001, 1'b0, 8'h51},
      '{3'h2, 16'h0080, 16'h0001, 1'b0, 8'h16},
      '{3'h0, 16'h0003, 16'h0000, 1'b0, 8'h04},
      '{3'h0, 16'h0007, 16'h0000, 1'b0, 8'h00},
      '{3'h0, 16'h0000, 16'h0000, 1'b0, 8'h44},
      '{3'h5, 16'h0000, 16'h0000, 1'b1, 8'h45},
      '{3'h3, 16'h7fff, 16'h0001, 1'b0, 8'h94},
      '{3'h4, 16'h8000, 16'h0001, 1'b0, 8'h16}};
   crs_addr_case_t addr_tab [7] = '{
      '{1'b0, 1'b0, 1'b0, 2'h0, 8'h00, 16'h1011},
      '{1'b0, 1'b0, 1'b0, 2'h1, 8'h00, 16'h1213},
      '{1'b0, 1'b0, 1'b0, 2'h2, 8'h00, 16'h1415},
      '{1'b1, 1'b0, 1'b0, 2'h0, 8'h80, 16'h19ab},
      '{1'b1, 1'b0, 1'b1, 2'h0, 8'hff, 16'h1a2c},
      '{1'b1, 1'b1, 1'b0, 2'h0, 8'h7f, 16'h3ccc},
      '{1'b1, 1'b1, 1'b1, 2'h0, 8'h05, 16'h3c48}};
   logic [1:0] pf [7] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3};
   logic [1:0] pv [7] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
   logic [15:0] pe [7] = '{16'h1011, 16'h1213, 16'h1415, 16'h1a2b,
      16'h3c4d, 16'h5e6f, 16'h1741};

   ////////////////////////////////////////
   // device under test
   crs_register_set dut_u (
      .clk_sys, .srst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest,
      .opcode_fetch_cycle, .pc_load, .pc_load_value, .vec_low,
      .vector_addr, .alu_valid, .alu_kind, .alu_a, .alu_b, .alu_cin,
      .shift_cout, .wb_valid, .wb_sel, .wb_data, .reg8_field,
      .reg8_data, .reg8_valid, .pair_field, .pair_var, .half_high,
      .pair_data, .pair_half, .ind_pair, .idx_mode, .idx_sel_b,
      .idx_disp, .idx_sub, .mem_addr, .stack_pointer,
      .program_counter, .condition_flags);

   // 200 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////
   // shared helpers
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test

   // one bus access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 16);
      if (avs_waitrequest !== 1'b0) begin
         mismatches++;
         stop_test();
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_sys);
   endtask : bus

   task automatic rdc(input logic [5:0] a, input logic [31:0] e,
                      input string what);
      bus(1'b0, a, 32'h0);
      check(what, rd, e);
   endtask : rdc

   ////////////////////////////////////////
   // scenarios
   task automatic t_reset;
      check("sp", stack_pointer, 32'h0);
      check("pc", program_counter, 32'h0);
      rdc(`CRS_OFS_VBASE, 32'h0, "vbase");
      rdc(`CRS_OFS_REFRESH, 32'h0, "refresh");
      rdc(`CRS_OFS_SP, 32'h0, "sp reg");
      rdc(`CRS_OFS_PC, 32'h0, "pc reg");
      $display("reset test done");
   endtask : t_reset

   task automatic t_fetch;
      bus(1'b1, `CRS_OFS_REFRESH, 32'h0000_00fe);
      bus(1'b1, `CRS_OFS_PC, 32'h0000_fffe);
      opcode_fetch_cycle <= 1'b1;
      repeat (3) @(posedge clk_sys);
      opcode_fetch_cycle <= 1'b0;
      @(negedge clk_sys);
      check("pc wrap", program_counter, 32'h1);
      @(posedge clk_sys);
      pc_load_value <= 16'h1234;
      pc_load <= 1'b1;
      @(posedge clk_sys);
      pc_load <= 1'b0;
      opcode_fetch_cycle <= 1'b1;
      @(posedge clk_sys);
      opcode_fetch_cycle <= 1'b0;
      @(negedge clk_sys);
      check("pc after jump", program_counter, 32'h1235);
      @(posedge clk_sys);
      rdc(`CRS_OFS_REFRESH, 32'h82, "refresh");
      bus(1'b1, `CRS_OFS_VBASE, 32'h0000_005a);
      vec_low <= 8'h34;
      @(posedge clk_sys);
      @(negedge clk_sys);
      check("vector", vector_addr, 32'h5a34);
      @(posedge clk_sys);
      $display("fetch test done");
   endtask : t_fetch

   task automatic t_flags;
      foreach (alu_tab[i]) begin
         @(posedge clk_sys);
         alu_kind <= crs_pkg::crs_alu_t'(alu_tab[i].k);
         alu_a <= alu_tab[i].a;
         alu_b <= alu_tab[i].b;
         shift_cout <= alu_tab[i].sc;
         alu_valid <= 1'b1;
         @(posedge clk_sys);
         @(negedge clk_sys);
         check("flag s", condition_flags[7], alu_tab[i].f[7]);
         check("flag z", condition_flags[6], alu_tab[i].f[6]);
         check("flag h", condition_flags[4], alu_tab[i].f[4]);
         check("flag p", condition_flags[2], alu_tab[i].f[2]);
         check("flag n", condition_flags[1], alu_tab[i].f[1]);
         check("flag c", condition_flags[0], alu_tab[i].f[0]);
         check("flag x", condition_flags & 8'h28, 32'h0);
      end
      @(posedge clk_sys);
      alu_valid <= 1'b0;
      @(posedge clk_sys);
      bus(1'b1, `CRS_OFS_FLAGS, 32'h0000_00ff);
      bus(1'b0, `CRS_OFS_FLAGS, 32'h0);
      check("flags rw", rd, 32'hd7);
      $display("flags test done");
   endtask : t_flags

   task automatic t_regs;
      wb_valid <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         wb_sel <= 3'(i);
         wb_data <= 8'h10 + 8'(i);
         @(posedge clk_sys);
      end
      wb_valid <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         reg8_field <= 3'(i);
         @(posedge clk_sys);
         @(negedge clk_sys);
         check("reg8 valid", reg8_valid, i != 6);
         if (i != 6) check("reg8", reg8_data, 8'h10 + 8'(i));
      end
      @(posedge clk_sys);
      rdc(`CRS_OFS_BC, 32'h1011, "bc");
      rdc(`CRS_OFS_HL, 32'h1415, "hl");
      rdc(`CRS_OFS_ACC, 32'h17, "acc");
      bus(1'b1, 6'h3c, 32'hffff_ffff);
      rdc(6'h3c, 32'h0, "unmapped");
      $display("register select test done");
   endtask : t_regs

   task automatic t_pairs;
      bus(1'b1, `CRS_OFS_IDXA, 32'h0000_1a2b);
      bus(1'b1, `CRS_OFS_IDXB, 32'h0000_3c4d);
      bus(1'b1, `CRS_OFS_SP, 32'h0000_5e6f);
      bus(1'b1, `CRS_OFS_FLAGS, 32'h0000_0041);
      for (int i = 0; i < 7; i++) begin
         @(posedge clk_sys);
         pair_field <= pf[i];
         pair_var <= crs_pkg::crs_var_t'(pv[i]);
         half_high <= i[0];
         @(posedge clk_sys);
         @(negedge clk_sys);
         check("pair", pair_data, pe[i]);
         check("half", pair_half, i[0] ? pe[i][15:8] : pe[i][7:0]);
      end
      for (int i = 0; i < 7; i++) begin
         @(posedge clk_sys);
         idx_mode <= addr_tab[i].md;
         idx_sel_b <= addr_tab[i].sb;
         idx_sub <= addr_tab[i].sub;
         ind_pair <= addr_tab[i].ip;
         idx_disp <= addr_tab[i].d;
         @(posedge clk_sys);
         @(negedge clk_sys);
         check("mem addr", mem_addr, addr_tab[i].e);
      end
      @(posedge clk_sys);
      $display("pair and address test done");
   endtask : t_pairs

   ////////////////////////////////////////
   // main sequence
   initial begin
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      {opcode_fetch_cycle, pc_load, pc_load_value, vec_low} = '0;
      {alu_valid, alu_a, alu_b, alu_cin, shift_cout} = '0;
      {wb_valid, wb_sel, wb_data, reg8_field, pair_field} = '0;
      {half_high, ind_pair, idx_mode, idx_sel_b, idx_disp, idx_sub} = '0;
      alu_kind = crs_pkg::CRS_ALU_LOGIC;
      pair_var = crs_pkg::CRS_VAR_HL;
      mismatches = 0;
      checks_done = 0;
      srst = 1'b1;
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      t_reset();
      t_fetch();
      t_flags();
      t_regs();
      t_pairs();
      stop_test();
   end
endmodule : testbench
